/* hdl/dam_top.sv */
// alarm monitor: pattern and limit compare, event queue, alarm output lines
// What this block does
// RULE1 - match mode alarms when masked data equals
// RULE2 - mismatch mode alarms when masked data differs
// RULE3 - zero mask bits are ignored in compare
// RULE4 - enabled totalizer alarms when count reaches limit
// RULE5 - two paths, each channel routed to one
// RULE6 - conditions evaluated always, scan or not
// RULE7 - queue holds 20, newer events dropped
// RULE8 - entry holds reading, absolute time, channel
// RULE9 - clear status, power, readout empty queue
// RULE10 - each read pops the oldest event
// RULE11 - scan stores alarm status even when full
// RULE12 - new scan erases reading memory, not queue
// RULE13 - function change disables alarms, clears limits
// RULE14 - leaving scan keeps limits and enables
// RULE15 - factory reset clears limits, enables, outputs
// RULE16 - compare spans channel width from lowest channel
// RULE17 - output line is OR of routed channels
// RULE18 - sticky mode holds line until cleared
// RULE19 - follow mode line tracks the condition
// RULE20 - scan start clears lines; manual clear allowed
// RULE21 - one polarity for both; reset active-low
// RULE22 - one mode governs both lines
// RULE23 - log once per newly true condition
//
// Design decisions made here: the address map and the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
`include "dam_defines.svh"
module dam_top (
    input wire logic sys_clk, // system clock, 100 MHz
    input wire logic srst, // synchronous reset, power cycle
    input wire logic wb_cyc_i, // wishbone cycle
    input wire logic wb_stb_i, // wishbone strobe
    input wire logic wb_we_i, // wishbone write
    input wire logic [7:0] wb_adr_i, // wishbone byte address
    input wire logic [3:0] wb_sel_i, // wishbone byte lanes
    input wire logic [31:0] wb_dat_i, // wishbone write data
    output logic [31:0] wb_dat_o, // wishbone read data
    output logic wb_ack_o, // wishbone acknowledge
    input wire logic [31:0] dig_in, // digital bank, channel n in byte n
    input wire logic [31:0] tot_count0, // totalizer channel 4 count
    input wire logic [31:0] tot_count1, // totalizer channel 5 count
    input wire logic [31:0] tod_in, // absolute time of day and date
    input wire logic scan_strobe, // a channel is being scanned
    input wire logic [2:0] scan_chan, // channel being scanned
    output logic rdm_wr, // reading memory write pulse
    output logic [2:0] rdm_chan, // channel of stored reading
    output logic [31:0] rdm_reading, // stored reading
    output logic rdm_alarm, // stored alarm status
    output logic rdm_clear, // reading memory erase pulse
    output logic [1:0] alarm_out // alarm path lines, polarity applied
);
    ////////////////////////////////////////////////////////////////////////
    // declarations
    logic busy_reg; // bus request seen, answer next cycle
    logic commit; // register access happens now
    logic [31:0] cfg_reg [0:`DAM_NUM_CH-1]; // channel config
    logic [31:0] data_reg [0:`DAM_NUM_CH-1]; // pattern or upper limit
    logic [31:0] mask_reg [0:`DAM_NUM_CH-1]; // pattern mask
    dam_pkg::dam_out_mode_t mode_reg; // output line mode
    logic pol_reg; // 1 active high, 0 active low
    logic scan_reg; // scan running
    logic [5:0] cond; // live alarm condition per channel
    logic [5:0] cond_reg; // condition one cycle ago
    logic [5:0] rise; // newly true conditions
    logic [5:0] pend_reg; // events waiting to be logged
    logic [5:0] pend_next; // next pending set
    logic [5:0] serve; // event logged this cycle, one-hot
    logic [1:0] path_any; // level of each path
    logic [1:0] path_rise; // new event on each path
    logic [1:0] latch_reg; // sticky state of each path
    logic [1:0] clr_line; // clear request per line
    logic ctrl_wr; // control register written
    logic [31:0] ctrl_val; // control write data on enabled lanes
    logic frst; // factory reset pulse
    logic cls; // clear status pulse
    logic scan_go; // scan start pulse
    logic [`DAM_QAW-1:0] head_reg; // oldest slot
    logic [`DAM_QAW-1:0] tail_reg; // next free slot
    logic [`DAM_QAW-1:0] q_count_reg; // entries held
    logic fresh_reg; // head written last edge, data not yet out
    logic push; // entry written this cycle
    logic pop; // oldest entry removed this cycle
    logic [2:0] serve_ch; // channel being logged
    logic [`DAM_ENTRY_W-1:0] q_rd; // entry at head
    logic [31:0] qtime_reg; // time of last popped entry
    logic [2:0] qchan_reg; // channel of last popped entry

    ////////////////////////////////////////////////////////////////////////
    // functions
    // byte window of a digital channel from its own byte upward
    function automatic logic [31:0] win_mask(input int ch, input logic [1:0] w);
        logic [31:0] m;
        int n;
        m = 32'h0000_0000;
        n = (w == `DAM_WIDTH_LWORD) ? 4 : int'(w) + 1;
        for (int b = 0; b < `DAM_NUM_DIG; b++) begin
            if (b >= ch && b < ch + n) begin
                m[8*b +: 8] = 8'hFF;
            end
        end
        return m;
    endfunction

    // reading seen on a channel
    function automatic logic [31:0] chan_reading(input logic [2:0] ch);
        logic [31:0] r;
        r = 32'h0000_0000;
        if (ch == 3'h4) begin
            r = tot_count0;
        end else if (ch == 3'h5) begin
            r = tot_count1;
        end else if (ch < 3'h4) begin
            r = dig_in & win_mask(int'(ch), cfg_reg[ch][`DAM_CFG_WIDTH]);
        end
        return r;
    endfunction

    // next queue slot with wrap
    function automatic logic [`DAM_QAW-1:0] q_inc(input logic [`DAM_QAW-1:0] p);
        return (p == `DAM_QLAST) ? '0 : p + 5'h01;
    endfunction

    // byte lane merge of a write
    function automatic logic [31:0] lane_merge(input logic [31:0] o, input logic [31:0] n);
        logic [31:0] r;
        r = o;
        for (int b = 0; b < 4; b++) begin
            if (wb_sel_i[b]) begin
                r[8*b +: 8] = n[8*b +: 8];
            end
        end
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // wishbone handshake: request seen, then ack one cycle later
    assign commit = wb_cyc_i & wb_stb_i & busy_reg & ~wb_ack_o;
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            busy_reg <= 1'b0;
            wb_ack_o <= 1'b0;
        end else begin
            busy_reg <= wb_cyc_i & wb_stb_i & ~busy_reg & ~wb_ack_o;
            wb_ack_o <= commit;
        end
    end

    // control register strobes, only on written lanes
    assign ctrl_wr = commit & wb_we_i & (wb_adr_i == `DAM_ADDR_CTRL);
    assign ctrl_val = lane_merge(32'h0000_0000, wb_dat_i);
    assign frst = ctrl_wr & ctrl_val[`DAM_CTRL_FRST];
    assign cls = ctrl_wr & ctrl_val[`DAM_CTRL_CLS];
    assign scan_go = ctrl_wr & ctrl_val[`DAM_CTRL_SCAN_GO];
    assign clr_line = {2{ctrl_wr}} & {ctrl_val[`DAM_CTRL_CLR2], ctrl_val[`DAM_CTRL_CLR1]};

    // output mode and polarity, shared by both lines
    always_ff @(posedge sys_clk) begin
        if (srst || frst) begin
            mode_reg <= dam_pkg::DAM_MODE_STICKY; // [RULE22]
            pol_reg <= `DAM_RST_POL; // [RULE21]
        end else if (ctrl_wr) begin
            if (wb_sel_i[0]) begin
                mode_reg <= dam_pkg::dam_out_mode_t'(wb_dat_i[`DAM_CTRL_MODE]); // [RULE22]
                pol_reg <= wb_dat_i[`DAM_CTRL_POL]; // [RULE21]
            end
        end
    end

    // scan running flag; preset aborts a scan, limits untouched
    always_ff @(posedge sys_clk) begin
        if (srst || frst) begin
            scan_reg <= 1'b0;
        end else if (scan_go) begin
            scan_reg <= 1'b1;
        end else if (ctrl_wr && (ctrl_val[`DAM_CTRL_SCAN_STOP] || ctrl_val[`DAM_CTRL_PRESET])) begin
            scan_reg <= 1'b0;
        end
    end

    // channel registers
    always_ff @(posedge sys_clk) begin
        logic [31:0] nc;
        nc = 32'h0000_0000;
        if (srst || frst) begin
            for (int i = 0; i < `DAM_NUM_CH; i++) begin
                cfg_reg[i] <= 32'h0000_0000; // [RULE15]
                data_reg[i] <= 32'h0000_0000; // [RULE15]
                mask_reg[i] <= 32'h0000_0000;
            end
        end else if (commit && wb_we_i && wb_adr_i[7:4] >= `DAM_CH_FIRST
                     && wb_adr_i[7:4] <= `DAM_CH_LAST) begin
            for (int i = 0; i < `DAM_NUM_CH; i++) begin
                if (wb_adr_i[7:4] == `DAM_CH_FIRST + 4'(i)) begin
                    unique case (wb_adr_i[3:2])
                        `DAM_SUB_CFG: begin
                            nc = lane_merge(cfg_reg[i], wb_dat_i) & `DAM_CFG_USED;
                            // new function: alarms off, limits gone
                            if (nc[`DAM_CFG_FUNC] != cfg_reg[i][`DAM_CFG_FUNC]) begin
                                nc[`DAM_CFG_EN] = 1'b0; // [RULE13]
                                data_reg[i] <= 32'h0000_0000; // [RULE13]
                                mask_reg[i] <= 32'h0000_0000; // [RULE13]
                            end
                            // leaving the scan only touches the scan bit
                            cfg_reg[i] <= nc; // [RULE14] [RULE5]
                        end
                        `DAM_SUB_DATA: data_reg[i] <= lane_merge(data_reg[i], wb_dat_i);
                        `DAM_SUB_MASK: mask_reg[i] <= lane_merge(mask_reg[i], wb_dat_i);
                        default: ;
                    endcase
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // alarm conditions, always live whether scanned or not
    always_comb begin
        logic [31:0] m;
        m = 32'h0000_0000;
        for (int i = 0; i < `DAM_NUM_DIG; i++) begin
            // window starts at this channel, zero mask bits ignored
            m = mask_reg[i] & win_mask(i, cfg_reg[i][`DAM_CFG_WIDTH]); // [RULE16] [RULE3]
            cond[i] = cfg_reg[i][`DAM_CFG_EN] // [RULE6]
                      & (cfg_reg[i][`DAM_CFG_MIS] // [RULE2]
                         ? (((dig_in ^ data_reg[i]) & m) != 32'h0000_0000)
                         : (((dig_in ^ data_reg[i]) & m) == 32'h0000_0000)); // [RULE1]
        end
        cond[4] = cfg_reg[4][`DAM_CFG_EN] & (tot_count0 >= data_reg[4]); // [RULE4]
        cond[5] = cfg_reg[5][`DAM_CFG_EN] & (tot_count1 >= data_reg[5]); // [RULE4]
    end

    // previous conditions for edge detection
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            cond_reg <= 6'h00;
        end else begin
            cond_reg <= cond;
        end
    end

    // path levels and new events; each channel feeds one path
    assign rise = cond & ~cond_reg; // [RULE23]
    always_comb begin
        path_any = 2'h0;
        path_rise = 2'h0;
        for (int i = 0; i < `DAM_NUM_CH; i++) begin
            path_any[cfg_reg[i][`DAM_CFG_PATH]] |= cond[i]; // [RULE17] [RULE5]
            path_rise[cfg_reg[i][`DAM_CFG_PATH]] |= rise[i];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // event logging: lowest pending channel logged each cycle
    always_comb begin
        serve = pend_reg & (~pend_reg + 6'h01);
        serve_ch = 3'h0;
        for (int i = `DAM_NUM_CH - 1; i >= 0; i--) begin
            if (serve[i]) begin
                serve_ch = 3'(i);
            end
        end
        pend_next = (pend_reg & ~serve) | rise; // [RULE23]
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            pend_reg <= 6'h00;
        end else begin
            pend_reg <= pend_next;
        end
    end

    // full queue drops the newer event, oldest kept
    assign push = (serve != 6'h00) && (q_count_reg != `DAM_QDEPTH); // [RULE7]
    assign pop = commit && !wb_we_i && (wb_adr_i == `DAM_ADDR_QPOP)
                 && (q_count_reg != '0) && !fresh_reg; // [RULE10]

    // queue pointers; clear status empties but keeps a same-cycle event
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            head_reg <= '0; // [RULE9]
            tail_reg <= '0;
            q_count_reg <= '0;
            fresh_reg <= 1'b0;
        end else begin
            fresh_reg <= push && (q_count_reg == '0 || cls);
            tail_reg <= push ? q_inc(tail_reg) : tail_reg;
            if (cls) begin
                head_reg <= tail_reg; // [RULE9]
                q_count_reg <= push ? 5'h01 : 5'h00;
            end else begin
                head_reg <= pop ? q_inc(head_reg) : head_reg; // [RULE10]
                q_count_reg <= q_count_reg + (push ? 5'h01 : 5'h00) - (pop ? 5'h01 : 5'h00);
            end
        end
    end

    // entry: reading, absolute time, channel
    dam_queue_mem u_qmem (
        .sys_clk(sys_clk),
        .wr_en(push),
        .wr_addr(tail_reg),
        .wr_data({serve_ch, tod_in, chan_reading(serve_ch)}), // [RULE8]
        .rd_addr(head_reg),
        .rd_data(q_rd)
    );

    // bus read data; popped entry fields held for later reads
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            wb_dat_o <= 32'h0000_0000;
            qtime_reg <= 32'h0000_0000;
            qchan_reg <= 3'h0;
        end else if (commit && !wb_we_i) begin
            wb_dat_o <= 32'h0000_0000;
            if (pop) begin
                wb_dat_o <= q_rd[`DAM_E_READ]; // [RULE10]
                qtime_reg <= q_rd[`DAM_E_TIME]; // [RULE8]
                qchan_reg <= q_rd[`DAM_E_CHAN];
            end else if (wb_adr_i == `DAM_ADDR_CTRL) begin
                wb_dat_o[`DAM_CTRL_MODE] <= mode_reg;
                wb_dat_o[`DAM_CTRL_POL] <= pol_reg;
            end else if (wb_adr_i == `DAM_ADDR_STAT) begin
                wb_dat_o[`DAM_ST_COUNT] <= q_count_reg;
                wb_dat_o[`DAM_ST_OUT] <= latch_reg;
                wb_dat_o[`DAM_ST_SCAN] <= scan_reg;
                wb_dat_o[`DAM_ST_COND] <= cond;
            end else if (wb_adr_i == `DAM_ADDR_QTIME) begin
                wb_dat_o <= qtime_reg;
            end else if (wb_adr_i == `DAM_ADDR_QCHAN) begin
                wb_dat_o[2:0] <= qchan_reg;
            end else if (wb_adr_i[7:4] >= `DAM_CH_FIRST && wb_adr_i[7:4] <= `DAM_CH_LAST) begin
                for (int i = 0; i < `DAM_NUM_CH; i++) begin
                    if (wb_adr_i[7:4] == `DAM_CH_FIRST + 4'(i)) begin
                        unique case (wb_adr_i[3:2])
                            `DAM_SUB_CFG: wb_dat_o <= cfg_reg[i];
                            `DAM_SUB_DATA: wb_dat_o <= data_reg[i];
                            `DAM_SUB_MASK: wb_dat_o <= mask_reg[i];
                            default: wb_dat_o <= 32'h0000_0000;
                        endcase
                    end
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // reading memory feed while scanning, independent of the queue
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            rdm_wr <= 1'b0;
            rdm_chan <= 3'h0;
            rdm_reading <= 32'h0000_0000;
            rdm_alarm <= 1'b0;
            rdm_clear <= 1'b0;
        end else begin
            rdm_clear <= scan_go; // [RULE12]
            rdm_wr <= scan_reg && scan_strobe && scan_chan < 3'h6
                      && cfg_reg[scan_chan][`DAM_CFG_INSCAN]; // [RULE11] [RULE14]
            rdm_chan <= scan_chan;
            rdm_reading <= chan_reading(scan_chan);
            rdm_alarm <= (scan_chan < 3'h6) ? cond[scan_chan] : 1'b0; // [RULE11]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // sticky state per path; a new event wins over a clear
    always_ff @(posedge sys_clk) begin
        for (int p = 0; p < 2; p++) begin
            if (srst) begin
                latch_reg[p] <= 1'b0;
            end else if (path_rise[p]) begin
                latch_reg[p] <= 1'b1; // [RULE18]
            end else if (scan_go || frst || clr_line[p]) begin
                latch_reg[p] <= 1'b0; // [RULE20] [RULE15]
            end
        end
    end

    // output lines with the shared mode and polarity
    always_ff @(posedge sys_clk) begin
        logic [1:0] act;
        act = (mode_reg == dam_pkg::DAM_MODE_FOLLOW) ? path_any : latch_reg; // [RULE19] [RULE22]
        if (srst || frst) begin
            alarm_out <= 2'h3; // [RULE15] [RULE21]
        end else begin
            alarm_out <= pol_reg ? act : ~act; // [RULE21]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    a_queue_bound: assert property (@(posedge sys_clk) disable iff (srst) // [RULE7]
        q_count_reg <= `DAM_QDEPTH) else $error("queue above depth");
    a_full_drops: assert property (@(posedge sys_clk) disable iff (srst) // [RULE7]
        (q_count_reg == `DAM_QDEPTH && !pop && !cls)
        |=> q_count_reg == `DAM_QDEPTH && $stable(tail_reg))
        else $error("full queue accepted an entry");
    a_pop_oldest: assert property (@(posedge sys_clk) disable iff (srst) // [RULE10]
        (pop && !push && !cls) |=> q_count_reg == $past(q_count_reg) - 5'h01
        && head_reg == q_inc($past(head_reg))) else $error("pop did not remove one");
    a_cls_empties: assert property (@(posedge sys_clk) disable iff (srst) // [RULE9]
        (cls && !push) |=> q_count_reg == 5'h00) else $error("clear status left entries");
    a_frst_keeps_queue: assert property (@(posedge sys_clk) disable iff (srst) // [RULE9]
        (frst && !cls && !pop) |=> q_count_reg >= $past(q_count_reg))
        else $error("factory reset lost entries");
    // a pop or clear in the logging cycle would move the count as well
    a_event_logged: assert property (@(posedge sys_clk) disable iff (srst) // [RULE23]
        (rise != 6'h00 && pend_reg == 6'h00 && q_count_reg < `DAM_QLAST && !cls && !pop)
        ##1 (!cls && !pop) |=> q_count_reg == $past(q_count_reg, 2) + 5'h01)
        else $error("event not logged");
    a_sticky_hold: assert property (@(posedge sys_clk) disable iff (srst) // [RULE18]
        (mode_reg == dam_pkg::DAM_MODE_STICKY && latch_reg[0] && !scan_go && !frst && !clr_line[0])
        |=> latch_reg[0]) else $error("sticky line dropped");
    a_scan_clears: assert property (@(posedge sys_clk) disable iff (srst) // [RULE20] [RULE12]
        (scan_go && path_rise == 2'h0) |=> latch_reg == 2'h0 && rdm_clear)
        else $error("scan start kept lines");
    // line was launched with the polarity that stood before the edge
    a_follow_line: assert property (@(posedge sys_clk) disable iff (srst) // [RULE19]
        (mode_reg == dam_pkg::DAM_MODE_FOLLOW && !frst && $stable(mode_reg) && $stable(pol_reg))
        |=> alarm_out[0] == ($past(path_any[0]) ~^ $past(pol_reg)))
        else $error("follow line wrong");
    a_frst_outputs: assert property (@(posedge sys_clk) disable iff (srst) // [RULE15]
        frst |=> alarm_out == 2'h3 && !pol_reg && cond == 6'h00) else $error("factory reset");
    a_func_change: assert property (@(posedge sys_clk) disable iff (srst) // [RULE13]
        (commit && wb_we_i && wb_adr_i == 8'h40 && wb_sel_i[1]
         && wb_dat_i[11:8] != cfg_reg[0][`DAM_CFG_FUNC])
        |=> !cfg_reg[0][`DAM_CFG_EN] && data_reg[0] == 32'h0000_0000)
        else $error("function change kept alarm");
    c_queue_full: cover property (@(posedge sys_clk) q_count_reg == `DAM_QDEPTH);
    c_pop_entry: cover property (@(posedge sys_clk) pop);
    c_scan_store: cover property (@(posedge sys_clk) rdm_wr && rdm_alarm);
    c_follow_drop: cover property (@(posedge sys_clk)
        mode_reg == dam_pkg::DAM_MODE_FOLLOW && $fell(path_any[1]));
endmodule
`default_nettype wire

/* hdl/dam_defines.svh */
// address map, field positions, reset values and sizes of the alarm monitor
`ifndef DAM_DEFINES_SVH
`define DAM_DEFINES_SVH

// channel counts and sizes
`define DAM_NUM_CH 6
`define DAM_NUM_DIG 4
`define DAM_QDEPTH 5'h14
`define DAM_QLAST 5'h13
`define DAM_QAW 5
`define DAM_ENTRY_W 67
// queue entry layout
`define DAM_E_READ 31:0
`define DAM_E_TIME 63:32
`define DAM_E_CHAN 66:64
// register byte addresses
`define DAM_ADDR_CTRL 8'h00
`define DAM_ADDR_STAT 8'h04
`define DAM_ADDR_QPOP 8'h08
`define DAM_ADDR_QTIME 8'h0C
`define DAM_ADDR_QCHAN 8'h10
`define DAM_CH_FIRST 4'h4
`define DAM_CH_LAST 4'h9
`define DAM_SUB_CFG 2'h0
`define DAM_SUB_DATA 2'h1
`define DAM_SUB_MASK 2'h2
// control register bits
`define DAM_CTRL_MODE 0
`define DAM_CTRL_POL 1
`define DAM_CTRL_CLR1 4
`define DAM_CTRL_CLR2 5
`define DAM_CTRL_SCAN_GO 8
`define DAM_CTRL_SCAN_STOP 9
`define DAM_CTRL_CLS 10
`define DAM_CTRL_FRST 11
`define DAM_CTRL_PRESET 12
// channel config bits
`define DAM_CFG_EN 0
`define DAM_CFG_MIS 1
`define DAM_CFG_PATH 2
`define DAM_CFG_INSCAN 3
`define DAM_CFG_WIDTH 5:4
`define DAM_CFG_FUNC 11:8
`define DAM_CFG_USED 32'h0000_0F3F
// status register fields
`define DAM_ST_COUNT 4:0
`define DAM_ST_OUT 9:8
`define DAM_ST_SCAN 12
`define DAM_ST_COND 21:16
// reset values and width codes
`define DAM_RST_POL 1'h0
`define DAM_WIDTH_LWORD 2'h3

`endif

/* hdl/dam_pkg.sv */
// shared types of the alarm monitor
package dam_pkg;
    typedef enum logic {DAM_MODE_STICKY, DAM_MODE_FOLLOW} dam_out_mode_t; // output line mode
    typedef logic [2:0] dam_chan_t; // channel number
endpackage

/* hdl/dam_queue_mem.sv */
// storage array of the alarm event queue with registered read
`timescale 1ns/1ps
`default_nettype none
`include "dam_defines.svh"
module dam_queue_mem (
    input wire logic sys_clk, // system clock
    input wire logic wr_en, // write strobe
    input wire logic [`DAM_QAW-1:0] wr_addr, // write slot
    input wire logic [`DAM_ENTRY_W-1:0] wr_data, // entry written
    input wire logic [`DAM_QAW-1:0] rd_addr, // read slot
    output logic [`DAM_ENTRY_W-1:0] rd_data // entry read, one cycle late
);
    logic [`DAM_ENTRY_W-1:0] mem_reg [0:`DAM_QLAST]; // entry slots

    // write port
    always_ff @(posedge sys_clk) begin
        if (wr_en) begin
            mem_reg[wr_addr] <= wr_data;
        end
    end

    // registered read port
    always_ff @(posedge sys_clk) begin
        rd_data <= mem_reg[rd_addr];
    end
endmodule
`default_nettype wire

/* sim/dam_alarm_lamp.sv */
// far-side model: alarm lamps lit from the two alarm lines
`timescale 1ns/1ps
`default_nettype none
module dam_alarm_lamp (
    input wire logic sys_clk, // system clock
    input wire logic [1:0] alarm_out, // alarm lines from the block
    input wire logic active_high, // polarity the lamps expect
    output logic [1:0] lit // lamp on per path
);
    // lamp decodes line level with the shared polarity, one lamp per path
    always_ff @(posedge sys_clk) begin
        lit <= active_high ? alarm_out : ~alarm_out;
    end
endmodule
`default_nettype wire

/* sim/test_dam_top.sv */
// self-checking bench of the alarm monitor
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin n_mismatch++; \
    $display("ERROR %0t got %h want %h", $time, a, e); end end
module test_dam_top;
    logic sys_clk, srst, cyc, stb, we, act_hi, rdm_wr, rdm_alarm, rdm_clear, sstb;
    logic [7:0] adr;
    logic [31:0] dwr, wb_dat_o, dig_in, tot0, q, rdm_reading;
    logic wb_ack_o;
    logic [1:0] alarm_out, lit;
    logic [2:0] rdm_chan, sch;
    int n_mismatch = 0;
    int checks_done = 0;
    int n_clr = 0;
    ////////////////////////////////////////////////////////////////
    dam_top u_dut (.sys_clk(sys_clk), .srst(srst), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dwr), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .dig_in(dig_in), .tot_count0(tot0), .tot_count1(32'h0000_0000),
        .tod_in(32'h0000_1234), .scan_strobe(sstb), .scan_chan(sch), .rdm_wr(rdm_wr),
        .rdm_chan(rdm_chan), .rdm_reading(rdm_reading), .rdm_alarm(rdm_alarm),
        .rdm_clear(rdm_clear), .alarm_out(alarm_out));
    dam_alarm_lamp u_lamp (.sys_clk(sys_clk), .alarm_out(alarm_out), .active_high(act_hi),
        .lit(lit));
    // one classic wishbone cycle, held until ack is seen
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dwr <= d;
        do @(posedge sys_clk); while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic tick(input int n); repeat (n) @(posedge sys_clk); endtask
    // one scan strobe on a channel, store pulse seen one edge later
    task automatic strobe(input logic [2:0] c);
        sch <= c; sstb <= 1'b1; tick(1); sstb <= 1'b0; tick(1);
    endtask
    // erase pulses of reading memory
    always @(posedge sys_clk) if (rdm_clear === 1'b1) n_clr <= n_clr + 1;
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    // match on masked low nibble, path two, logged once while held
    task automatic t_match;
        xfer(1, 8'h44, 32'h06); xfer(1, 8'h48, 32'h0F); xfer(1, 8'h40, 32'h05);
        dig_in <= 32'h0000_00F6; tick(6);
        `CHK(alarm_out, 2'b01)
        `CHK(lit, 2'b10)
        xfer(0, 8'h04, 0); `CHK(q[4:0], 5'h01)
        xfer(0, 8'h08, 0); `CHK(q, 32'h0000_00F6)
        xfer(0, 8'h0C, 0); `CHK(q, 32'h0000_1234)
        xfer(0, 8'h10, 0); `CHK(q[2:0], 3'h0)
        xfer(0, 8'h04, 0); `CHK(q[4:0], 5'h00)
        dig_in <= 32'h0000_0010; tick(4); `CHK(alarm_out, 2'b01)
        xfer(1, 8'h00, 32'h20); tick(3); `CHK(alarm_out, 2'b11)
        $display("test match done");
    endtask
    // follow mode on totalizer limit and on mismatch compare
    task automatic t_follow;
        xfer(1, 8'h00, 32'h01); xfer(1, 8'h84, 32'd100); xfer(1, 8'h80, 32'h01);
        tot0 <= 32'd100; tick(4); `CHK(alarm_out, 2'b10)
        tot0 <= 32'd5; tick(4); `CHK(alarm_out, 2'b11)
        xfer(1, 8'h40, 32'h07); tick(4); `CHK(alarm_out, 2'b01)
        dig_in <= 32'h0000_0016; tick(4); `CHK(alarm_out, 2'b11)
        $display("test follow done");
    endtask
    // queue overflow, polarity, preset, factory reset and clear status
    task automatic t_queue;
        xfer(1, 8'h00, 32'h401);
        for (int i = 0; i < 25; i++) begin
            dig_in <= 32'h10; tick(2); dig_in <= 32'h16; tick(2);
        end
        xfer(0, 8'h04, 0); `CHK(q[4:0], 5'h14)
        xfer(1, 8'h00, 32'h03); act_hi <= 1'b1; tick(3);
        `CHK(alarm_out, 2'b00)
        `CHK(lit, 2'b00)
        xfer(1, 8'h00, 32'h1003); xfer(0, 8'h40, 0); `CHK(q[0], 1'b1)
        xfer(1, 8'h00, 32'h800); act_hi <= 1'b0; xfer(0, 8'h04, 0);
        `CHK(q[4:0], 5'h14)
        `CHK(alarm_out, 2'b11)
        xfer(0, 8'h40, 0); `CHK(q[0], 1'b0)
        xfer(1, 8'h00, 32'h400); xfer(0, 8'h04, 0); `CHK(q[4:0], 5'h00)
        $display("test queue done");
    endtask
    // scan start, reading memory feed, leaving the scan, function change
    task automatic t_scan;
        xfer(1, 8'h40, 32'h09); tick(2); `CHK(alarm_out, 2'b10)
        xfer(1, 8'h00, 32'h100); tick(2);
        `CHK(alarm_out, 2'b11)
        `CHK(n_clr, 1)
        strobe(3'h0); `CHK({rdm_wr, rdm_chan, rdm_alarm}, 5'h11)
        `CHK(rdm_reading, 32'h0000_0016)
        xfer(1, 8'h40, 32'h01); strobe(3'h0); `CHK(rdm_wr, 1'b0)
        xfer(0, 8'h40, 0); `CHK(q[0], 1'b1)
        xfer(1, 8'h44, 32'h16); xfer(1, 8'h40, 32'h109); xfer(0, 8'h40, 0);
        `CHK(q, 32'h0000_0108)
        xfer(0, 8'h44, 0); `CHK(q, 32'h0000_0000)
        $display("test scan done");
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin sys_clk = 1'b0; forever #5 sys_clk = ~sys_clk; end
    initial begin #300000; n_mismatch++; report_and_stop(); end
    initial begin
        srst = 1'b1; cyc = 0; stb = 0; we = 0; adr = 0; dwr = 0; dig_in = 0; tot0 = 0;
        act_hi = 0; sstb = 0; sch = 0;
        tick(4); srst <= 1'b0; tick(2);
        `CHK(alarm_out, 2'b11)
        t_match(); t_follow(); t_queue(); t_scan();
        report_and_stop();
    end
endmodule
`default_nettype wire
